// ---- verilog/ptplat_regs.sv ----
// Top: AXI4-Lite register bank for port 1 egress timestamps and port 2 calibration
//
// Overview of operation
// RULE_01: The Delay_Req/Pdelay_Req egress low word holds nanoseconds 15..0 and is readable and writable.
// RULE_02: Its high word holds seconds 1..0 in bits 15..14 and nanoseconds 29..16 in bits 13..0.
// RULE_03: The Sync egress low word holds nanoseconds 15..0 and resets to zero.
// RULE_04: The Sync egress high word holds seconds 1..0 on top and nanoseconds 29..16 below.
// RULE_05: The Pdelay_Resp egress low word holds nanoseconds 15..0.
// RULE_06: The Pdelay_Resp egress high word holds seconds 1..0 in 15..14 and nanoseconds 29..16 in 13..0.
// RULE_07: Port 2 receive latency is a 16-bit nanosecond setting resetting to 415.
// RULE_08: Port 2 transmit latency is a 16-bit nanosecond setting resetting to 45.
// RULE_09: Port 2 asymmetry is sign-magnitude, bit 15 set meaning the 15-bit magnitude is negative.
// RULE_10: The asymmetry is added for ingress Sync/Pdelay_Resp and subtracted for egress requests.
// RULE_11: Port 2 link delay is a 16-bit readable and writable nanosecond setting resetting to zero.
// RULE_12: Each port 1 egress of a timestamped class overwrites both words of that class together.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module ptplat_regs
    import ptplat_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Port 1 egress capture, one-cycle strobes per class
    input wire logic [N_CLASS-1:0] p1_egress_cap_i,
    input wire logic [1:0] p1_egress_sec_i,
    input wire logic [29:0] p1_egress_ns_i,
    // Port 2 correction field update
    input wire logic p2_corr_valid_i,
    input wire logic p2_corr_ingress_i,
    input wire logic [63:0] p2_corr_i,
    output logic p2_corr_valid_o,
    output logic [63:0] p2_corr_o,
    // Port 2 settings to the timestamp path
    output logic [15:0] p2_receive_latency_o,
    output logic [15:0] p2_transmit_latency_o,
    output logic [15:0] p2_link_delay_o
);

    // ==================================================
    // Write channel capture
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic [11:0] wr_idx;
    logic wr_hit;

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
    assign wr_go = aw_held && w_held && !s_axi_bvalid_o;
    assign wr_idx = aw_addr[ADDR_W-1:IDX_LSB];

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    // ==================================================
    // Write decode
    logic [N_CLASS-1:0] wr_low;
    logic [N_CLASS-1:0] wr_high;
    logic wr_rx;
    logic wr_tx;
    logic wr_asym;
    logic wr_link;

    always_comb begin
        wr_low = '0;
        wr_high = '0;
        wr_rx = 1'b0;
        wr_tx = 1'b0;
        wr_asym = 1'b0;
        wr_link = 1'b0;
        wr_hit = 1'b1;
        if (wr_idx == P1_DREQ_LOW_IDX) begin
            wr_low[CLS_DREQ] = wr_go;
        end else if (wr_idx == P1_DREQ_HIGH_IDX) begin
            wr_high[CLS_DREQ] = wr_go;
        end else if (wr_idx == P1_SYNC_LOW_IDX) begin
            wr_low[CLS_SYNC] = wr_go;
        end else if (wr_idx == P1_SYNC_HIGH_IDX) begin
            wr_high[CLS_SYNC] = wr_go;
        end else if (wr_idx == P1_PRESP_LOW_IDX) begin
            wr_low[CLS_PRESP] = wr_go;
        end else if (wr_idx == P1_PRESP_HIGH_IDX) begin
            wr_high[CLS_PRESP] = wr_go;
        end else if (wr_idx == P2_RX_LAT_IDX) begin
            wr_rx = wr_go;
        end else if (wr_idx == P2_TX_LAT_IDX) begin
            wr_tx = wr_go;
        end else if (wr_idx == P2_ASYM_IDX) begin
            wr_asym = wr_go;
        end else if (wr_idx == P2_LINK_DLY_IDX) begin
            wr_link = wr_go;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ==================================================
    // Timestamp words, one instance per class
    logic [15:0] ts_low [N_CLASS];
    logic [15:0] ts_high [N_CLASS];

    generate
        for (genvar c = 0; c < N_CLASS; c++) begin : g_cls
            ptplat_ts_word u_ts (
                .core_clk_i(core_clk_i),
                .nrst_i(nrst_i),
                .cap_i(p1_egress_cap_i[c]), // RULE_12
                .cap_sec_i(p1_egress_sec_i),
                .cap_ns_i(p1_egress_ns_i),
                .wr_low_i(wr_low[c]), // RULE_01 RULE_03 RULE_05
                .wr_high_i(wr_high[c]), // RULE_02 RULE_04 RULE_06
                .wdata_i(w_data[15:0]),
                .wstrb_i(w_strb[1:0]),
                .low_o(ts_low[c]),
                .high_o(ts_high[c])
            );
        end
    endgenerate

    // ==================================================
    // Port 2 calibration settings
    logic [15:0] p2_asym;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            p2_receive_latency_o <= RX_LAT_RESET; // RULE_07
        end else if (wr_rx) begin
            p2_receive_latency_o <= merge(p2_receive_latency_o, w_data[15:0], w_strb[1:0]); // RULE_07
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            p2_transmit_latency_o <= TX_LAT_RESET; // RULE_08
        end else if (wr_tx) begin
            p2_transmit_latency_o <= merge(p2_transmit_latency_o, w_data[15:0], w_strb[1:0]); // RULE_08
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            p2_asym <= ASYM_RESET;
        end else if (wr_asym) begin
            p2_asym <= merge(p2_asym, w_data[15:0], w_strb[1:0]); // RULE_09
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            p2_link_delay_o <= LINK_DLY_RESET; // RULE_11
        end else if (wr_link) begin
            p2_link_delay_o <= merge(p2_link_delay_o, w_data[15:0], w_strb[1:0]); // RULE_11
        end
    end

    ptplat_asym_adj u_asym (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .asym_i(p2_asym),
        .valid_i(p2_corr_valid_i),
        .ingress_i(p2_corr_ingress_i), // RULE_10
        .corr_i(p2_corr_i),
        .valid_o(p2_corr_valid_o),
        .corr_o(p2_corr_o)
    );

    // ==================================================
    // Read channel
    logic [11:0] rd_idx;
    logic [15:0] rd_val;
    logic rd_hit;

    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign rd_idx = s_axi_araddr_i[ADDR_W-1:IDX_LSB];

    always_comb begin
        rd_val = 16'h0000;
        rd_hit = 1'b1;
        if (rd_idx == P1_DREQ_LOW_IDX) begin
            rd_val = ts_low[CLS_DREQ]; // RULE_01
        end else if (rd_idx == P1_DREQ_HIGH_IDX) begin
            rd_val = ts_high[CLS_DREQ]; // RULE_02
        end else if (rd_idx == P1_SYNC_LOW_IDX) begin
            rd_val = ts_low[CLS_SYNC]; // RULE_03
        end else if (rd_idx == P1_SYNC_HIGH_IDX) begin
            rd_val = ts_high[CLS_SYNC]; // RULE_04
        end else if (rd_idx == P1_PRESP_LOW_IDX) begin
            rd_val = ts_low[CLS_PRESP]; // RULE_05
        end else if (rd_idx == P1_PRESP_HIGH_IDX) begin
            rd_val = ts_high[CLS_PRESP]; // RULE_06
        end else if (rd_idx == P2_RX_LAT_IDX) begin
            rd_val = p2_receive_latency_o;
        end else if (rd_idx == P2_TX_LAT_IDX) begin
            rd_val = p2_transmit_latency_o;
        end else if (rd_idx == P2_ASYM_IDX) begin
            rd_val = p2_asym;
        end else if (rd_idx == P2_LINK_DLY_IDX) begin
            rd_val = p2_link_delay_o; // RULE_11
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Data sampled at address acceptance; upper half reads zero
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {16'h0000, rd_val};
            s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

endmodule

// ---- common/ptplat_pkg.sv ----
// Package with register map, field layout and reset values of the timestamp and latency bank
package ptplat_pkg;

    // ==================================================
    // Register indices (printed offsets are not all multiples of four)
    localparam logic [11:0] P1_DREQ_LOW_IDX = 12'h0648;
    localparam logic [11:0] P1_DREQ_HIGH_IDX = 12'h064a;
    localparam logic [11:0] P1_SYNC_LOW_IDX = 12'h064c;
    localparam logic [11:0] P1_SYNC_HIGH_IDX = 12'h064e;
    localparam logic [11:0] P1_PRESP_LOW_IDX = 12'h0650;
    localparam logic [11:0] P1_PRESP_HIGH_IDX = 12'h0652;
    localparam logic [11:0] P2_RX_LAT_IDX = 12'h0660;
    localparam logic [11:0] P2_TX_LAT_IDX = 12'h0662;
    localparam logic [11:0] P2_ASYM_IDX = 12'h0664;
    localparam logic [11:0] P2_LINK_DLY_IDX = 12'h0666;
    // Byte address is four times the index
    localparam int ADDR_W = 14;
    localparam int IDX_LSB = 2;

    // ==================================================
    // Field layout
    localparam int HIGH_SEC_MSB = 15;
    localparam int HIGH_SEC_LSB = 14;
    localparam int HIGH_NS_MSB = 13;
    localparam int ASYM_SIGN_BIT = 15;
    localparam int ASYM_MAG_MSB = 14;
    localparam int NS_LOW_MSB = 15;
    localparam int NS_HIGH_LSB = 16;
    localparam int NS_HIGH_MSB = 29;

    // ==================================================
    // Reset values
    localparam logic [15:0] TS_RESET = 16'h0000;
    localparam logic [15:0] RX_LAT_RESET = 16'h019f;
    localparam logic [15:0] TX_LAT_RESET = 16'h002d;
    localparam logic [15:0] ASYM_RESET = 16'h0000;
    localparam logic [15:0] LINK_DLY_RESET = 16'h0000;

    // ==================================================
    // Timestamp classes and AXI responses
    localparam int N_CLASS = 3;
    localparam int CLS_DREQ = 0;
    localparam int CLS_SYNC = 1;
    localparam int CLS_PRESP = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- verilog/ptplat_ts_word.sv ----
// One timestamp class: low and high words, written by capture or by software
`timescale 1ns/1ns
module ptplat_ts_word
    import ptplat_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Capture
    input wire logic cap_i,
    input wire logic [1:0] cap_sec_i,
    input wire logic [29:0] cap_ns_i,
    // Software write
    input wire logic wr_low_i,
    input wire logic wr_high_i,
    input wire logic [15:0] wdata_i,
    input wire logic [1:0] wstrb_i,
    // Contents
    output logic [15:0] low_o,
    output logic [15:0] high_o
);

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Capture overrides a same-cycle software write so a fresh time is never torn
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            low_o <= TS_RESET;
            high_o <= TS_RESET;
        end else if (cap_i) begin
            low_o <= cap_ns_i[NS_LOW_MSB:0]; // RULE_12
            high_o <= {cap_sec_i, cap_ns_i[NS_HIGH_MSB:NS_HIGH_LSB]}; // RULE_12
        end else begin
            if (wr_low_i) begin
                low_o <= merge(low_o, wdata_i, wstrb_i);
            end
            if (wr_high_i) begin
                high_o <= merge(high_o, wdata_i, wstrb_i);
            end
        end
    end

endmodule

// ---- verilog/ptplat_asym_adj.sv ----
// Applies the sign-magnitude asymmetry to a correction field
`timescale 1ns/1ns
module ptplat_asym_adj
    import ptplat_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Setting
    input wire logic [15:0] asym_i,
    // Request
    input wire logic valid_i,
    input wire logic ingress_i,
    input wire logic [63:0] corr_i,
    // Result
    output logic valid_o,
    output logic [63:0] corr_o
);

    logic [63:0] mag;
    logic neg;

    always_comb begin
        mag = {49'h0, asym_i[ASYM_MAG_MSB:0]}; // RULE_09
        // Ingress adds the signed value, egress subtracts it
        neg = asym_i[ASYM_SIGN_BIT] ^ ~ingress_i; // RULE_09 RULE_10
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            valid_o <= 1'b0;
        end else begin
            valid_o <= valid_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            corr_o <= 64'h0000_0000_0000_0000;
        end else if (valid_i) begin
            corr_o <= neg ? corr_i - mag : corr_i + mag; // RULE_10
        end
    end

endmodule

// ---- bench/ptplat_regs_checker.sv ----
// Port-level assertions for the timestamp and latency register bank
`timescale 1ns/1ns
module ptplat_regs_checker
    import ptplat_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Bus handshakes
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    // Correction path
    input wire logic p2_corr_valid_i,
    input wire logic [63:0] p2_corr_i,
    input wire logic p2_corr_valid_o,
    input wire logic [63:0] p2_corr_o,
    // Settings
    input wire logic [15:0] p2_receive_latency_o,
    input wire logic [15:0] p2_transmit_latency_o,
    input wire logic [15:0] p2_link_delay_o
);
    // ==========
    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    property p_rx_rst;
        $rose(nrst_i) |-> p2_receive_latency_o == RX_LAT_RESET;
    endproperty
    a_rx_rst: assert property (p_rx_rst) else $error("rx latency not at reset value");
    property p_tx_rst;
        $rose(nrst_i) |-> p2_transmit_latency_o == TX_LAT_RESET;
    endproperty
    a_tx_rst: assert property (p_tx_rst) else $error("tx latency not at reset value");
    property p_link_rst;
        $rose(nrst_i) |-> p2_link_delay_o == LINK_DLY_RESET;
    endproperty
    a_link_rst: assert property (p_link_rst) else $error("link delay not at reset value");
    // Settings may only move with a write response
    property p_set_hold;
        disable iff (!nrst_i) $past(nrst_i) && !$rose(s_axi_bvalid_o)
            |-> $stable({p2_receive_latency_o, p2_transmit_latency_o, p2_link_delay_o});
    endproperty
    a_set_hold: assert property (p_set_hold) else $error("setting changed without write");
    property p_wr_ans;
        disable iff (!nrst_i) s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
            |-> ##[1:2] s_axi_bvalid_o;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_rd_ans;
        disable iff (!nrst_i) s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_corr_lat;
        disable iff (!nrst_i) $past(nrst_i) |-> p2_corr_valid_o == $past(p2_corr_valid_i);
    endproperty
    a_corr_lat: assert property (p_corr_lat) else $error("correction valid latency wrong");
    // Magnitude is only 15 bits wide
    property p_corr_rng;
        disable iff (!nrst_i) p2_corr_valid_i |=> $signed(p2_corr_o - $past(p2_corr_i)) < 64'sd32768
            && $signed(p2_corr_o - $past(p2_corr_i)) > -64'sd32768;
    endproperty
    a_corr_rng: assert property (p_corr_rng) else $error("correction step too large");
endmodule

bind ptplat_regs ptplat_regs_checker u_chk (.*);

// ---- bench/ptplat_regs_tb_top.sv ----
// Self-checking bench for the timestamp and latency register bank
`timescale 1ns/1ns
module ptplat_regs_tb_top
    import ptplat_pkg::*;
;
    typedef struct packed {logic [11:0] ix; logic [15:0] rv;} ptplat_row_s;
    logic core_clk_i, nrst_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic p2_corr_valid_i, p2_corr_ingress_i, p2_corr_valid_o;
    logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, p1_egress_sec_i;
    logic [N_CLASS-1:0] p1_egress_cap_i;
    logic [29:0] p1_egress_ns_i;
    logic [63:0] p2_corr_i, p2_corr_o;
    logic [15:0] p2_receive_latency_o, p2_transmit_latency_o, p2_link_delay_o;
    int n_fail = 0;
    int checked = 0;
    ptplat_row_s rows [10] = '{'{P1_DREQ_LOW_IDX, TS_RESET}, '{P1_DREQ_HIGH_IDX, TS_RESET},
        '{P1_SYNC_LOW_IDX, TS_RESET}, '{P1_SYNC_HIGH_IDX, TS_RESET}, '{P1_PRESP_LOW_IDX, TS_RESET},
        '{P1_PRESP_HIGH_IDX, TS_RESET}, '{P2_RX_LAT_IDX, RX_LAT_RESET}, '{P2_TX_LAT_IDX, TX_LAT_RESET},
        '{P2_ASYM_IDX, ASYM_RESET}, '{P2_LINK_DLY_IDX, LINK_DLY_RESET}};

    ptplat_regs u_dut (.*);

    always #4 core_clk_i = ~core_clk_i;

    // ==========
    // Shared tasks
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Handshakes sampled at the falling edge to stay clear of the rising-edge updates
    task automatic wr(input logic [11:0] ix, input logic [15:0] d, input logic [3:0] st, input logic [1:0] er);
        logic a;
        logic w;
        logic b;
        logic [1:0] r;
        s_axi_awaddr_i <= {ix, 2'b00};
        s_axi_wdata_i <= {16'h0000, d};
        s_axi_wstrb_i <= st;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(negedge core_clk_i);
            a = s_axi_awvalid_i && s_axi_awready_o;
            w = s_axi_wvalid_i && s_axi_wready_o;
            b = s_axi_bvalid_o;
            r = s_axi_bresp_o;
            @(posedge core_clk_i);
            if (a) s_axi_awvalid_i <= 1'b0;
            if (w) s_axi_wvalid_i <= 1'b0;
        end while (b !== 1'b1);
        s_axi_bready_i <= 1'b0;
        @(posedge core_clk_i);
        chk(r, er);
    endtask

    task automatic rd(input logic [11:0] ix, input logic [15:0] e, input logic [1:0] er);
        logic a;
        logic v;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr_i <= {ix, 2'b00};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(negedge core_clk_i);
            a = s_axi_arvalid_i && s_axi_arready_o;
            v = s_axi_rvalid_o;
            d = s_axi_rdata_o;
            r = s_axi_rresp_o;
            @(posedge core_clk_i);
            if (a) s_axi_arvalid_i <= 1'b0;
        end while (v !== 1'b1);
        s_axi_rready_i <= 1'b0;
        @(posedge core_clk_i);
        chk(d, {16'h0000, e});
        chk(r, er);
    endtask

    task automatic summarize;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========
    // Tests
    initial begin
        {core_clk_i, nrst_i, s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wdata_i, s_axi_wstrb_i, s_axi_wvalid_i,
            s_axi_bready_i, s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i, p1_egress_cap_i, p1_egress_sec_i,
            p1_egress_ns_i, p2_corr_valid_i, p2_corr_ingress_i, p2_corr_i} = '0;
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(rows[i].ix, rows[i].rv, RESP_OKAY);
            wr(rows[i].ix, 16'h5a00 + 16'(i), 4'hf, RESP_OKAY);
            rd(rows[i].ix, 16'h5a00 + 16'(i), RESP_OKAY);
        end
        $display("register rows done");
        for (int c = 0; c < N_CLASS; c++) begin
            p1_egress_cap_i <= 3'(1 << c);
            p1_egress_sec_i <= 2'(c + 1);
            p1_egress_ns_i <= 30'h2bcd_e123 + 30'(c);
            @(posedge core_clk_i);
            p1_egress_cap_i <= '0;
            rd(P1_DREQ_LOW_IDX + 12'(4 * c), 16'he123 + 16'(c), RESP_OKAY);
            rd(P1_DREQ_LOW_IDX + 12'(4 * c + 2), {2'(c + 1), 14'h2bcd}, RESP_OKAY);
        end
        // Capture lands on the same edge as a software write to that class
        fork
            wr(P1_SYNC_LOW_IDX, 16'h1111, 4'hf, RESP_OKAY);
            begin
                @(posedge core_clk_i);
                p1_egress_cap_i <= 3'b010;
                p1_egress_sec_i <= 2'h1;
                p1_egress_ns_i <= 30'h0001_7777;
                @(posedge core_clk_i);
                p1_egress_cap_i <= '0;
            end
        join
        rd(P1_SYNC_LOW_IDX, 16'h7777, RESP_OKAY);
        rd(P1_SYNC_HIGH_IDX, 16'h4001, RESP_OKAY);
        $display("capture done");
        for (int k = 0; k < 4; k++) begin
            wr(P2_ASYM_IDX, {k[1], 15'h0123}, 4'hf, RESP_OKAY);
            p2_corr_valid_i <= 1'b1;
            p2_corr_ingress_i <= k[0];
            p2_corr_i <= 64'h1000_0000;
            @(posedge core_clk_i);
            p2_corr_valid_i <= 1'b0;
            @(negedge core_clk_i);
            chk(p2_corr_valid_o, 1'b1);
            chk(p2_corr_o, (k[1] == k[0]) ? 64'h0fff_fedd : 64'h1000_0123);
            // Bus tasks must start just after a rising edge
            @(posedge core_clk_i);
        end
        $display("correction done");
        wr(P2_LINK_DLY_IDX, 16'h1234, 4'hf, RESP_OKAY);
        wr(P2_LINK_DLY_IDX, 16'habcd, 4'h2, RESP_OKAY);
        wr(P2_LINK_DLY_IDX, 16'hffff, 4'hc, RESP_OKAY);
        chk(p2_link_delay_o, 16'hab34);
        wr(12'h0654, 16'hffff, 4'hf, RESP_SLVERR);
        rd(12'h0654, 16'h0000, RESP_SLVERR);
        rd(P2_LINK_DLY_IDX, 16'hab34, RESP_OKAY);
        $display("strobe and unmapped done");
        wr(P2_RX_LAT_IDX, 16'h0001, 4'hf, RESP_OKAY);
        chk(p2_receive_latency_o, 16'h0001);
        nrst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        @(negedge core_clk_i);
        chk({p2_receive_latency_o, p2_transmit_latency_o, p2_link_delay_o},
            {RX_LAT_RESET, TX_LAT_RESET, LINK_DLY_RESET});
        $display("mid-run reset done");
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge core_clk_i);
        n_fail++;
        summarize();
    end
endmodule
